// *** core/nvs_defines.vh ***
// Constants for the serial nonvolatile byte memory slave
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH

// Array geometry
`define NVS_ADDR_W 9
`define NVS_DATA_W 8
`define NVS_DEPTH 512

// Slave address byte field positions
`define NVS_SA_TYPE_HI 7
`define NVS_SA_TYPE_LO 4
`define NVS_SA_CS_HI 3
`define NVS_SA_CS_LO 2
`define NVS_SA_PAGE 1
`define NVS_SA_RW 0

// Bit counts within one byte
`define NVS_LAST_BIT 4'h7
`define NVS_BYTE_END 4'h8
`define NVS_CNT_ZERO 4'h0
`define NVS_CNT_ONE 4'h1

// Reset values
`define NVS_ADDR_RST 9'h000
`define NVS_BYTE_RST 8'h00

// Number of synchronised pin inputs
`define NVS_SYNC_W 5

`endif

// *** core/nvs_array.v ***
// Flip-flop storage for the 512 x 8 byte array
`timescale 1ns/1ps
`include "nvs_defines.vh"

module nvs_array (
   input wire clk_i,
   input wire we_i,
   input wire [`NVS_ADDR_W-1:0] waddr_i,
   input wire [`NVS_DATA_W-1:0] wdata_i,
   input wire [`NVS_ADDR_W-1:0] raddr_i,
   output wire [`NVS_DATA_W-1:0] rdata_o
);

   // Storage cells, contents unknown until written
   reg [`NVS_DATA_W-1:0] cells [0:`NVS_DEPTH-1];

   ////////////////////////////////////////////////////////////////
   // Single write port, one byte per strobe
   always @(posedge clk_i) begin
      if (we_i) begin
         cells[waddr_i] <= wdata_i;
      end
   end

   // Read port, no latency
   assign rdata_o = cells[raddr_i];

endmodule

// *** core/nvs_i2c_slave.v ***
// Two-wire slave front end for a 512 x 8 nonvolatile byte memory
//
// Behaviour
// - STOP: SDA rises while SCL high
// - STOP abandons any transaction, back to idle
// - START: SDA falls while SCL high
// - START anywhere restarts slave address reception
// - SDA sampled only while SCL high
// - Ninth clock carries acknowledge from receiver
// - Missing master acknowledge ends the operation
// - Upper nibble must match device type
// - Bits 3-2 must match chip-select straps
// - Bit 1 selects 256-byte half
// - Bit 0: one reads, zero writes
// - Write: next byte loads low address
// - Read: page bit plus latched low byte
// - Address increments per byte, wraps to zero
// - No limit on bytes per transaction
// - Read: send eight bits, then check acknowledge
// - Write: take eight bits, then acknowledge
// - Bytes travel most significant bit first
// - Array written at eighth data bit
// - No busy period after a write
// - Write protect refuses data, holds address
// - Sample on SCL rise, drive on fall
// - Repeated START turns write into read
// - Read data starts right after address acknowledge
`timescale 1ns/1ps
`include "nvs_defines.vh"

module nvs_i2c_slave #(
   // Device type code; value is arbitrary
   parameter [3:0] DEV_TYPE = 4'h6
) (
   input wire CLK_SYS_I,
   input wire RST_I,
   input wire SCL_I,
   input wire SDA_I,
   input wire [1:0] CHIP_SELECT_STRAPS_I,
   input wire WRITE_PROTECT_I,
   output wire SDA_O,
   output wire SDA_OE_O,
   output wire BUSY_O,
   output wire SELECTED_O,
   output wire WP_BLOCK_O
);

   ////////////////////////////////////////////////////////////////
   // One-hot states
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_SLV = 9'h002;
   localparam [8:0] ST_SACK = 9'h004;
   localparam [8:0] ST_WORD = 9'h008;
   localparam [8:0] ST_WACK = 9'h010;
   localparam [8:0] ST_WDAT = 9'h020;
   localparam [8:0] ST_DACK = 9'h040;
   localparam [8:0] ST_RDAT = 9'h080;
   localparam [8:0] ST_MACK = 9'h100;

   ////////////////////////////////////////////////////////////////
   // Declarations
   wire [`NVS_SYNC_W-1:0] pin_raw;
   reg [`NVS_SYNC_W-1:0] sync_a;
   reg [`NVS_SYNC_W-1:0] sync_b;
   reg scl_prev;
   reg sda_prev;
   wire scl_s;
   wire sda_s;
   wire wp_s;
   wire [1:0] cs_s;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   reg [8:0] state;
   reg [3:0] cnt;
   reg [7:0] rx;
   wire [7:0] next_rx;
   reg [7:0] tx;
   reg page;
   reg ack_en;
   reg mack;
   reg [`NVS_ADDR_W-1:0] addr;
   wire [`NVS_ADDR_W-1:0] next_addr;
   reg mem_we;
   reg [`NVS_ADDR_W-1:0] mem_waddr;
   reg [`NVS_DATA_W-1:0] mem_wdata;
   wire [`NVS_DATA_W-1:0] mem_rdata;
   reg sda_low;
   reg sda_oe;
   reg busy;
   reg selected;
   reg wp_block;

   ////////////////////////////////////////////////////////////////
   // Slave address check against type code and straps
   function addr_match;
      input [7:0] sa;
      input [1:0] straps;
      begin
         addr_match = (sa[`NVS_SA_TYPE_HI:`NVS_SA_TYPE_LO] == DEV_TYPE) &&
            (sa[`NVS_SA_CS_HI:`NVS_SA_CS_LO] == straps);
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for every pin input
   assign pin_raw = {CHIP_SELECT_STRAPS_I, WRITE_PROTECT_I, SDA_I, SCL_I};

   genvar gi;
   generate
      for (gi = 0; gi < `NVS_SYNC_W; gi = gi + 1) begin : g_sync
         always @(posedge CLK_SYS_I) begin
            if (RST_I) begin
               sync_a[gi] <= 1'b1;
               sync_b[gi] <= 1'b1;
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   // Synchronised pin levels
   assign scl_s = sync_b[0];
   assign sda_s = sync_b[1];
   assign wp_s = sync_b[2];
   assign cs_s = sync_b[4:3];

   ////////////////////////////////////////////////////////////////
   // Previous levels for edge finding
   always @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_s;
         sda_prev <= sda_s;
      end
   end

   // Edges and bus conditions on synchronised lines
   assign scl_rise = scl_s & ~scl_prev;
   assign scl_fall = ~scl_s & scl_prev;
   assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_det = scl_s & scl_prev & ~sda_prev & sda_s;

   // Incoming byte, most significant bit first
   assign next_rx = {rx[6:0], sda_s};

   // Address latch step with wrap from top to zero
   assign next_addr = addr + 9'h001;

   ////////////////////////////////////////////////////////////////
   // Byte array
   nvs_array u_array (
      .clk_i(CLK_SYS_I),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(mem_wdata),
      .raddr_i(addr),
      .rdata_o(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////
   // Protocol state machine
   always @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         state <= ST_IDLE;
         cnt <= `NVS_CNT_ZERO;
         rx <= `NVS_BYTE_RST;
         tx <= `NVS_BYTE_RST;
         page <= 1'b0;
         ack_en <= 1'b0;
         mack <= 1'b0;
         addr <= `NVS_ADDR_RST;
         mem_we <= 1'b0;
         mem_waddr <= `NVS_ADDR_RST;
         mem_wdata <= `NVS_BYTE_RST;
         sda_oe <= 1'b0;
         wp_block <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         wp_block <= 1'b0;
         if (start_det) begin
            // Fresh slave address after any START
            state <= ST_SLV;
            cnt <= `NVS_CNT_ZERO;
            mack <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_det) begin
            // Drop whatever was under way
            state <= ST_IDLE;
            cnt <= `NVS_CNT_ZERO;
            mack <= 1'b0;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  cnt <= `NVS_CNT_ZERO;
               end
               ST_SLV: begin
                  if (scl_rise) begin
                     rx <= next_rx;
                     cnt <= cnt + `NVS_CNT_ONE;
                     if (cnt == `NVS_LAST_BIT) begin
                        cnt <= `NVS_CNT_ZERO;
                        if (addr_match(next_rx, cs_s)) begin
                           page <= next_rx[`NVS_SA_PAGE];
                           if (next_rx[`NVS_SA_RW]) begin
                              addr[8] <= next_rx[`NVS_SA_PAGE];
                           end
                           ack_en <= 1'b1;
                           state <= ST_SACK;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_WORD: begin
                  if (scl_rise) begin
                     rx <= next_rx;
                     cnt <= cnt + `NVS_CNT_ONE;
                     if (cnt == `NVS_LAST_BIT) begin
                        cnt <= `NVS_CNT_ZERO;
                        addr <= {page, next_rx};
                        ack_en <= 1'b1;
                        state <= ST_WACK;
                     end
                  end
               end
               ST_WDAT: begin
                  if (scl_rise) begin
                     rx <= next_rx;
                     cnt <= cnt + `NVS_CNT_ONE;
                     if (cnt == `NVS_LAST_BIT) begin
                        cnt <= `NVS_CNT_ZERO;
                        state <= ST_DACK;
                        if (wp_s) begin
                           // Protected: no ack, address held
                           ack_en <= 1'b0;
                           wp_block <= 1'b1;
                        end else begin
                           mem_we <= 1'b1;
                           mem_waddr <= addr;
                           mem_wdata <= next_rx;
                           addr <= next_addr;
                           ack_en <= 1'b1;
                        end
                     end
                  end
               end
               ST_SACK, ST_WACK, ST_DACK: begin
                  // Ninth clock: drive low on first fall if ack_en, free on second unless a read starts
                  if (scl_fall) begin
                     if (cnt == `NVS_CNT_ZERO) begin
                        cnt <= `NVS_CNT_ONE;
                        sda_oe <= ack_en;
                     end else begin
                        cnt <= `NVS_CNT_ZERO;
                        sda_oe <= 1'b0;
                        if (state == ST_SACK) begin
                           if (rx[`NVS_SA_RW]) begin
                              // First read bit on the very next fall
                              sda_oe <= ~mem_rdata[7];
                              tx <= {mem_rdata[6:0], 1'b0};
                              cnt <= `NVS_CNT_ONE;
                              state <= ST_RDAT;
                           end else begin
                              state <= ST_WORD;
                           end
                        end else if (state == ST_WACK) begin
                           state <= ST_WDAT;
                        end else if (ack_en) begin
                           state <= ST_WDAT;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_RDAT: begin
                  if (scl_fall) begin
                     if (cnt == `NVS_BYTE_END) begin
                        // Release for master ack, step address first
                        sda_oe <= 1'b0;
                        addr <= next_addr;
                        cnt <= `NVS_CNT_ZERO;
                        state <= ST_MACK;
                     end else begin
                        sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                        cnt <= cnt + `NVS_CNT_ONE;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     if (sda_s) begin
                        state <= ST_IDLE;
                     end else begin
                        mack <= 1'b1;
                     end
                  end else if (scl_fall && mack) begin
                     // Acknowledged: next sequential byte
                     mack <= 1'b0;
                     sda_oe <= ~mem_rdata[7];
                     tx <= {mem_rdata[6:0], 1'b0};
                     cnt <= `NVS_CNT_ONE;
                     state <= ST_RDAT;
                  end
               end
               default: begin
                  state <= ST_IDLE;
                  cnt <= `NVS_CNT_ZERO;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Status flags from current state
   always @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         busy <= 1'b0;
         selected <= 1'b0;
         sda_low <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE);
         selected <= (state != ST_IDLE) && (state != ST_SLV);
         sda_low <= 1'b0; // Open drain: only ever pulls low
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign SDA_O = sda_low;
   assign SDA_OE_O = sda_oe;
   assign BUSY_O = busy;
   assign SELECTED_O = selected;
   assign WP_BLOCK_O = wp_block;

endmodule

// *** tb/nvs_i2c_slave_asserts.sv ***
// Concurrent checks on the memory slave ports
`timescale 1ns/1ps
module nvs_slave_chk (
   input wire CLK_SYS_I,
   input wire RST_I,
   input wire SCL_I,
   input wire SDA_I,
   input wire [1:0] CHIP_SELECT_STRAPS_I,
   input wire WRITE_PROTECT_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   input wire BUSY_O,
   input wire SELECTED_O,
   input wire WP_BLOCK_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   // Properties on the pins, sampled by the system clock
   a_drive_low_only: assert property (!SDA_O)
      else $error("data output not low");
   a_reset_idle: assert property ($past(RST_I) |-> !SDA_OE_O && !BUSY_O && !SELECTED_O)
      else $error("not idle after reset");
   a_stop_idle: assert property (SCL_I && $past(SCL_I) && $rose(SDA_I)
      |-> ##[1:8] (!BUSY_O && !SDA_OE_O))
      else $error("stop did not idle");
   a_start_drop: assert property (SCL_I && $past(SCL_I) && $fell(SDA_I)
      |-> ##[1:8] !SELECTED_O)
      else $error("start did not deselect");
   a_oe_rise_low: assert property ($rose(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
      else $error("drive began while clock high");
   a_oe_hold_high: assert property ((SCL_I && $stable(SDA_I)) [*4] |-> $stable(SDA_OE_O))
      else $error("drive changed while clock high");
   a_wp_pulse: assert property (WP_BLOCK_O |-> $past(WRITE_PROTECT_I, 3) ##1 !WP_BLOCK_O)
      else $error("bad protect pulse");
   a_wp_no_ack: assert property ($rose(WP_BLOCK_O) |-> !SDA_OE_O [*8])
      else $error("refused byte acknowledged");
   a_sel_busy: assert property (SELECTED_O |-> BUSY_O)
      else $error("selected while idle");
endmodule
bind nvs_i2c_slave nvs_slave_chk u_chk (
   .CLK_SYS_I(CLK_SYS_I),
   .RST_I(RST_I),
   .SCL_I(SCL_I),
   .SDA_I(SDA_I),
   .CHIP_SELECT_STRAPS_I(CHIP_SELECT_STRAPS_I),
   .WRITE_PROTECT_I(WRITE_PROTECT_I),
   .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O),
   .BUSY_O(BUSY_O),
   .SELECTED_O(SELECTED_O),
   .WP_BLOCK_O(WP_BLOCK_O)
);

// *** tb/nvs_mst_model.sv ***
// Two-wire bus master model, open-drain data
`timescale 1ns/1ps
module nvs_mst_model (
   input wire sda_i,
   output reg scl_o,
   output reg oe_o
);
   localparam real Q = 31.25;
   // Bus idle: clock high, data released
   initial begin
      scl_o = 1'b1;
      oe_o = 1'b0;
   end
   ////////////////////
   // One clock: data set mid-low, sampled mid-high
   task bit_x(input b, output r);
      begin
         #Q oe_o = ~b;
         #Q scl_o = 1'b1;
         #Q r = sda_i;
         #Q scl_o = 1'b0;
      end
   endtask
   // Data falls while clock high
   task start;
      begin
         #Q oe_o = 1'b0;
         #Q scl_o = 1'b1;
         #Q oe_o = 1'b1;
         #Q scl_o = 1'b0;
      end
   endtask
   // Data rises while clock high, clock then stands
   task stop;
      begin
         #Q oe_o = 1'b1;
         #Q scl_o = 1'b1;
         #Q oe_o = 1'b0;
         #Q;
      end
   endtask
   // Byte out, then release for the ack clock
   task put_byte(input [7:0] d, output ack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_x(d[i], r);
         bit_x(1'b1, r);
         ack = ~r;
      end
   endtask
   // Byte in, then own ack or withheld ack
   task get_byte(output [7:0] d, input mack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_x(1'b1, d[i]);
         bit_x(~mack, r);
      end
   endtask
endmodule

// *** tb/test_nvs_i2c_slave.sv ***
// Self-checking bench for the memory slave
`timescale 1ns/1ps
module test_nvs_i2c_slave;
   localparam [3:0] TYPE = 4'h6; // Arbitrary type code
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg wp = 1'b0;
   reg [1:0] straps = 2'h2;
   reg [31:0] seed = 32'hABBC;
   reg [7:0] mem [0:511];
   reg [8:0] ptr;
   reg [8:0] radr;
   reg [7:0] wp_hits = 8'h00;
   reg [7:0] d;
   reg ack;
   integer fail_count = 0;
   integer checks = 0;
   integer cyc = 0;
   integer n;
   wire scl, m_oe, sda_oe, sda_o, busy, sel, wp_blk;
   // Open-drain wire: device drives its data output only while enabled
   wire sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
   always #5 clk = ~clk;
   nvs_mst_model u_mst (.sda_i(sda), .scl_o(scl), .oe_o(m_oe));
   nvs_i2c_slave #(.DEV_TYPE(TYPE)) u_dut (
      .CLK_SYS_I(clk),
      .RST_I(rst),
      .SCL_I(scl),
      .SDA_I(sda),
      .CHIP_SELECT_STRAPS_I(straps),
      .WRITE_PROTECT_I(wp),
      .SDA_O(sda_o),
      .SDA_OE_O(sda_oe),
      .BUSY_O(busy),
      .SELECTED_O(sel),
      .WP_BLOCK_O(wp_blk)
   );
   // Count refused-byte pulses
   always @(posedge clk) begin
      if (wp_blk === 1'b1) wp_hits <= wp_hits + 8'h01;
   end
   ////////////////////
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function sel_exp(input [3:0] ty, input [1:0] cs);
      sel_exp = (ty == TYPE) && (cs == straps);
   endfunction
   task chk_ack(input got, input exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t ack %b exp %b", $time, got, exp);
         end
      end
   endtask
   task chk_flag(input got, input exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
         end
      end
   endtask
   task chk_data(input [7:0] got, input [7:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t data %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Address, word, then cnt random bytes
   task write_bytes(input [8:0] adr, input integer cnt, input fin);
      integer k;
      begin
         u_mst.start;
         u_mst.put_byte({TYPE, straps, adr[8], 1'b0}, ack);
         chk_ack(ack, 1'b1);
         chk_flag(sel, 1'b1);
         u_mst.put_byte(adr[7:0], ack);
         chk_ack(ack, 1'b1);
         ptr = adr;
         for (k = 0; k < cnt; k = k + 1) begin
            seed = xs(seed);
            u_mst.put_byte(seed[7:0], ack);
            chk_ack(ack, !wp);
            if (!wp) begin
               mem[ptr] = seed[7:0];
               ptr = ptr + 1'b1;
            end
         end
         if (fin) u_mst.stop;
      end
   endtask
   // Current address read of cnt bytes
   task read_bytes(input pg, input integer cnt);
      integer k;
      begin
         u_mst.start;
         u_mst.put_byte({TYPE, straps, pg, 1'b1}, ack);
         chk_ack(ack, 1'b1);
         for (k = 0; k < cnt; k = k + 1) begin
            u_mst.get_byte(d, k < cnt - 1);
            chk_data(d, mem[{pg, ptr[7:0]}]);
            ptr = ptr + 1'b1;
         end
         u_mst.stop;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d fail_count %0d", checks, fail_count);
         if (fail_count == 0 && checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // Hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count = fail_count + 1;
         give_verdict;
      end
   end
   ////////////////////
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      // Foreign type code or straps stay silent
      for (n = 0; n < 4; n = n + 1) begin
         u_mst.start;
         u_mst.put_byte({n[0] ? TYPE : 4'h5, n[1] ? straps : ~straps, 2'h0}, ack);
         chk_ack(ack, sel_exp(n[0] ? TYPE : 4'h5, n[1] ? straps : ~straps));
         chk_flag(sel, sel_exp(n[0] ? TYPE : 4'h5, n[1] ? straps : ~straps));
         u_mst.stop;
      end
      // Idle again once the stop has passed the synchronisers
      repeat (4) @(posedge clk);
      chk_flag(busy, 1'b0);
      chk_flag(sel, 1'b0);
      // Write across the top, random then current read
      write_bytes(9'h1FE, 3, 1'b1);
      write_bytes(9'h1FE, 0, 1'b0);
      read_bytes(1'b1, 2);
      read_bytes(1'b0, 1);
      // Protected byte refused, latch held
      @(posedge clk) wp <= 1'b1;
      write_bytes(9'h1FE, 1, 1'b1);
      @(posedge clk) wp <= 1'b0;
      chk_data(wp_hits, 8'h01);
      read_bytes(1'b1, 1);
      // Partial byte then stop leaves memory; the stop's clock is bit seven
      write_bytes(9'h1FE, 0, 1'b0);
      for (n = 0; n < 6; n = n + 1) u_mst.bit_x(1'b0, ack);
      u_mst.stop;
      ptr = 9'h1FE;
      read_bytes(1'b1, 1);
      // Random locations and strap settings
      for (n = 0; n < 6; n = n + 1) begin
         seed = xs(seed);
         radr = seed[8:0] & 9'h1FE;
         @(posedge clk) straps <= seed[10:9];
         write_bytes(radr, 2, 1'b1);
         write_bytes(radr, 0, 1'b0);
         read_bytes(radr[8], 2);
      end
      give_verdict;
   end
endmodule
